// ===== tmr_group_pkg.sv
// package of constants and carriers for the countdown timer group
//
// What this block does
// - five 8-bit timers divide by reload plus one
// - reload zero passes every input pulse
// - base input is peripheral clock halved
// - one-clock output pulses, advance on pulse end
// - at zero, next input pulse reloads counter
// - reload writes allowed anytime, apply next reload
// - baud timers drive serial ports A to D
// - five timers share one interrupt and priority
// - status flags bits 1,4-7, cleared by read
// - no terminal count lost around status read
// - set flag with enable requests shared interrupt at nonzero priority level
// - flag cleared before latch raises no interrupt
// - bits 3,2 read zero; enables are write-only
// - bit 0 write gates base clock on/off
// - control bits 7-4 pick baud timer source
// - control bits 1-0 set interrupt priority level
// - reload registers write-only, reads return zero
// - global clock enable clear at power-up
package tmr_group_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'ha0;
  localparam logic [7:0] ADDR_PRESCALE_RELOAD = 8'ha3;
  localparam logic [7:0] ADDR_SOURCE_PRIORITY = 8'ha4;
  localparam logic [7:0] ADDR_BAUD0_RELOAD = 8'ha9;
  localparam logic [7:0] ADDR_BAUD1_RELOAD = 8'hab;
  localparam logic [7:0] ADDR_BAUD2_RELOAD = 8'had;
  localparam logic [7:0] ADDR_BAUD3_RELOAD = 8'haf;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_PRESCALE_FLAG = 1;
  localparam int BIT_BAUD_FLAG_LO = 4;
  localparam int BIT_BAUD_SRC_LO = 4;
  localparam int NUM_TIMERS = 5;
  localparam int NUM_BAUD = 4;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_SOURCE_PRIORITY = 8'h00;
  localparam logic [4:0] RST_ENABLES = 5'h00;
  localparam logic [1:0] PRIO_OFF = 2'h0;
  localparam int BASE_DIV = 2;

  // internal i/o bus request carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_t;

endpackage

// ===== tmr_group.sv
// countdown timer group: prescaler plus four baud timers
`timescale 1ns/1ps
module tmr_group
(
  input wire logic clk,
  input wire logic arst_n,
  input tmr_group_pkg::io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic [3:0] baud_tick,
  output logic prescale_tick,
  output logic irq_req,
  output logic [1:0] irq_prio
);
  import tmr_group_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PH_LOW = 2'b01, PH_HIGH = 2'b10} phase_t;

  phase_t phase_ff;
  logic gen_ff;
  logic [7:0] src_prio_ff;
  logic [4:0] ie_ff;
  logic [4:0] flag_ff;
  logic [7:0] reload_ff [NUM_TIMERS];
  logic [7:0] count_ff [NUM_TIMERS];
  logic [4:0] tick_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic is_reload_addr(input logic [7:0] a, input int idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      0: hit = (a == ADDR_PRESCALE_RELOAD);
      1: hit = (a == ADDR_BAUD0_RELOAD);
      2: hit = (a == ADDR_BAUD1_RELOAD);
      3: hit = (a == ADDR_BAUD2_RELOAD);
      4: hit = (a == ADDR_BAUD3_RELOAD);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  wire wr_cs = io_req.wr && (io_req.addr == ADDR_CTRL_STATUS);
  wire rd_cs = io_req.rd && (io_req.addr == ADDR_CTRL_STATUS);
  wire wr_sp = io_req.wr && (io_req.addr == ADDR_SOURCE_PRIORITY);
  // base pulse: every second clock, gated by the global enable
  wire base_pulse = gen_ff && (phase_ff == PH_HIGH);
  // each timer's input enable; baud sources pick base or prescaler
  logic [4:0] in_pulse;
  always_comb
  begin
    in_pulse[0] = base_pulse;
    for (int i = 0; i < NUM_BAUD; i++)
    begin
      in_pulse[i + 1] = src_prio_ff[BIT_BAUD_SRC_LO + i] ? tick_ff[0] : base_pulse;
    end
  end
  // a timer fires when its input pulse meets a zero count
  logic [4:0] fire;
  always_comb
  begin
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      fire[i] = in_pulse[i] && (count_ff[i] == 8'h00);
    end
  end
  // read view: flags with zero in bits 3,2 and bit 0
  wire [7:0] status_view = {flag_ff[4:1], 2'b00, flag_ff[0], 1'b0};
  wire [7:0] nxt_rdata = rd_cs ? status_view : 8'h00;
  // set wins over the read-clear, so no event slips by
  wire [4:0] nxt_flag = (rd_cs ? 5'h00 : flag_ff) | fire;
  // flags cleared by read never reach the request
  wire nxt_irq = ((flag_ff & ie_ff) != 5'h00) && !rd_cs && (src_prio_ff[1:0] != PRIO_OFF);

  // ---------------------------------------------------------------
  // base clock divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      phase_ff <= PH_LOW;
    else
      case (phase_ff)
        PH_LOW: phase_ff <= PH_HIGH;
        PH_HIGH: phase_ff <= PH_LOW;
        default: phase_ff <= PH_LOW;
      endcase
  end

  // control registers; enables are write-only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gen_ff <= 1'b0;
      ie_ff <= RST_ENABLES;
      src_prio_ff <= RST_SOURCE_PRIORITY;
    end
    else
    begin
      if (wr_cs)
      begin
        gen_ff <= io_req.wdata[BIT_GLOBAL_EN];
        ie_ff <= {io_req.wdata[7:4], io_req.wdata[BIT_PRESCALE_FLAG]};
      end
      if (wr_sp)
        src_prio_ff <= io_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // countdown timers, one clock domain with enables
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        reload_ff[i] <= RST_RELOAD;
        count_ff[i] <= RST_COUNT;
      end
      tick_ff <= 5'h00;
    end
    else
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        if (io_req.wr && is_reload_addr(io_req.addr, i))
          reload_ff[i] <= io_req.wdata;
        if (in_pulse[i])
          count_ff[i] <= fire[i] ? reload_ff[i] : count_ff[i] - 8'h01;
      end
      tick_ff <= fire;
    end
  end

  // status, read data, interrupt request
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag_ff <= 5'h00;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign io_rdata = rdata_ff;
  assign prescale_tick = tick_ff[0];
  assign baud_tick = tick_ff[4:1];
  assign irq_req = irq_ff;
  assign irq_prio = src_prio_ff[1:0];

  // ---------------------------------------------------------------
  // helper logic for the checks
  // ---------------------------------------------------------------
  // clocks since the global enable went low, saturating at three;
  // a tick launched just before the drop may still show one clock
  logic [1:0] off_ff;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      off_ff <= 2'h0;
    else if (gen_ff)
      off_ff <= 2'h0;
    else if (off_ff != 2'h3)
      off_ff <= off_ff + 2'h1;
  end

  // prescaler input pulses since its last tick; running past 255
  // would mean the reload path was skipped somewhere
  logic [8:0] since_ff;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      since_ff <= 9'h000;
    else if (fire[0])
      since_ff <= 9'h000;
    else if (in_pulse[0] && since_ff != 9'h1ff)
      since_ff <= since_ff + 9'h001;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_tick_one_clock: assert property (prescale_tick |=> !prescale_tick)
    else $error("prescale tick longer than one clock");
  chk_zero_reload_div1: assert property ((in_pulse[0] && count_ff[0] == 8'h00) |=> prescale_tick)
    else $error("zero count did not fire");
  chk_reload_load: assert property ((fire[1]) |=> count_ff[1] == $past(reload_ff[1]))
    else $error("counter not reloaded after zero");
  chk_decrement: assert property ((in_pulse[2] && count_ff[2] != 8'h00) |=> count_ff[2] == $past(count_ff[2]) - 8'h01)
    else $error("counter did not decrement");
  chk_gate_off: assert property (!gen_ff |-> in_pulse[0] == 1'b0)
    else $error("base pulse while clock disabled");
  chk_flag_set: assert property (prescale_tick |-> flag_ff[0])
    else $error("terminal count lost");
  chk_read_zero_bits: assert property ($past(rd_cs) |-> io_rdata[3:2] == 2'b00 && io_rdata[0] == 1'b0)
    else $error("reserved status bits not zero");
  chk_prio_off: assert property (irq_prio == PRIO_OFF |-> ##1 !irq_req)
    else $error("interrupt with priority off");
  chk_read_clears: assert property ((rd_cs && fire == 5'h00) |=> flag_ff == 5'h00)
    else $error("status read did not clear flags");
  chk_base_rate: assert property (base_pulse |=> !base_pulse)
    else $error("base pulse faster than half clock");

  // gating and period bounds
  chk_off_quiet: assert property (off_ff >= 2'h2 |-> tick_ff == 5'h00)
    else $error("tick while base clock gated off");
  chk_period_bound: assert property (since_ff <= 9'h0ff)
    else $error("prescaler period longer than reload plus one");
  chk_idle_hold: assert property (!in_pulse[0] |=> $stable(count_ff[0]))
    else $error("counter moved without input pulse");
  chk_prescaled_src: assert property (src_prio_ff[BIT_BAUD_SRC_LO] |-> in_pulse[1] == tick_ff[0])
    else $error("port a timer not fed by prescaler");

  // baud outputs and their flags
  chk_baud_one_clock: assert property ((baud_tick & $past(baud_tick)) == 4'h0)
    else $error("baud tick longer than one clock");
  chk_baud_flag_set: assert property ((baud_tick & ~flag_ff[4:1]) == 4'h0)
    else $error("baud terminal count lost");
  chk_status_read: assert property ($past(rd_cs) |-> io_rdata[7:4] == $past(flag_ff[4:1]))
    else $error("status read shows wrong flags");

  // interrupt request
  chk_irq_needs_flag: assert property (irq_req |-> $past((flag_ff & ie_ff) != 5'h00))
    else $error("interrupt without enabled flag");
  chk_irq_raise: assert property (((flag_ff & ie_ff) != 5'h00 && !rd_cs && irq_prio != PRIO_OFF) |=> irq_req)
    else $error("enabled flag did not request interrupt");
  chk_read_drops_irq: assert property (rd_cs |=> !irq_req)
    else $error("interrupt after flags were read");

  // reload registers
  chk_reload_write: assert property ((io_req.wr && io_req.addr == ADDR_BAUD3_RELOAD) |=> reload_ff[4] == $past(io_req.wdata))
    else $error("reload write not stored");
  chk_write_keeps_count: assert property ((io_req.wr && io_req.addr == ADDR_BAUD0_RELOAD && !in_pulse[1]) |=> count_ff[1] == $past(count_ff[1]))
    else $error("reload write disturbed running count");
  chk_other_reads_zero: assert property (($past(io_req.rd) && $past(io_req.addr) != ADDR_CTRL_STATUS) |-> io_rdata == 8'h00)
    else $error("write-only register readable");

  // every timer, not only the sampled ones, reloads and ticks
  for (genvar g = 0; g < NUM_TIMERS; g++)
  begin : gen_timer_chk
    chk_load_each: assert property (fire[g] |=> count_ff[g] == $past(reload_ff[g]))
      else $error("timer not reloaded after zero");
    chk_tick_each: assert property (fire[g] |=> tick_ff[g])
      else $error("fire without output tick");
  end

  cov_baud_tick: cover property (baud_tick[0]);
  cov_irq: cover property (irq_req ##1 rd_cs);
  cov_prescaled_baud: cover property (src_prio_ff[4] && baud_tick[0]);
  // the race between a read and a new event
  cov_read_with_fire: cover property (rd_cs && fire != 5'h00);
  cov_gate_off: cover property (gen_ff ##1 !gen_ff);
endmodule

// ===== serial_side.sv
// far side model: serial ports and prescale user timing the ticks
`timescale 1ns/1ps
module serial_side
(
  input wire logic clk,
  input wire logic [3:0] baud_tick,
  input wire logic prescale_tick,
  output int per [5]
);
  int cyc;
  int last [5];
  logic [4:0] tk;
  // index 1..4 are ports a..d, as each port's divider sees them
  assign tk = {baud_tick, prescale_tick};
  // spacing of ticks in clocks; a missing tick leaves per stale
  always @(posedge clk)
  begin
    cyc++;
    for (int i = 0; i < 5; i++)
      if (tk[i] === 1'b1)
      begin
        per[i] = cyc - last[i];
        last[i] = cyc;
      end
  end
endmodule

// ===== tb.sv
// self-checking bench for the countdown timer group
`timescale 1ns/1ps
module tb;
  import tmr_group_pkg::*;
  logic clk = 0;
  logic arst_n = 0;
  io_req_t io_req = '0;
  logic [7:0] io_rdata;
  logic [3:0] baud_tick;
  logic prescale_tick, irq_req;
  logic [1:0] irq_prio;
  int per [5];
  int failures = 0;
  int cmp_count = 0;
  int unsigned seed = 57;
  int rl [5];
  int held;
  logic [7:0] adr [5] = '{ADDR_PRESCALE_RELOAD, ADDR_BAUD0_RELOAD, ADDR_BAUD1_RELOAD,
    ADDR_BAUD2_RELOAD, ADDR_BAUD3_RELOAD};

  tmr_group tmr_group_inst (.clk(clk), .arst_n(arst_n), .io_req(io_req), .io_rdata(io_rdata),
    .baud_tick(baud_tick), .prescale_tick(prescale_tick), .irq_req(irq_req), .irq_prio(irq_prio));
  serial_side serial_side_inst (.clk(clk), .baud_tick(baud_tick), .prescale_tick(prescale_tick), .per(per));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    forever #20 clk = ~clk;
  end

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // one bus access; on a read, d is the expected data
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{w, !w, a, d};
    @(posedge clk);
    io_req <= '0;
    #1;
    if (!w)
      chk("rdata", d, io_rdata);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog, well past the ~1100 clocks needed
  // ----------------------------------------
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1;
    repeat (20) @(posedge clk);
    chk("idle_per", 8'h00, 8'(per[0]));
    acc(0, ADDR_CTRL_STATUS, 8'h00);
    acc(1, ADDR_SOURCE_PRIORITY, 8'h82);
    acc(1, ADDR_CTRL_STATUS, 8'hf3);
    // second pass rewrites reloads while running
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        rl[i] = (p == 0 && i == 1) ? 0 : int'(xs() % 4);
        acc(1, adr[i], 8'(rl[i]));
      end
      repeat (300) @(posedge clk);
      for (int i = 0; i < 5; i++)
        chk("period", 8'(2 * (rl[i] + 1) * ((i == 4) ? rl[0] + 1 : 1)), 8'(per[i]));
      chk("irq_prio", 8'h02, {6'h0, irq_prio});
      chk("irq_req", 8'h01, {7'h0, irq_req});
    end
    // zero two baud reloads, let both reload, then they tick together
    acc(1, ADDR_BAUD0_RELOAD, 8'h00);
    acc(1, ADDR_BAUD1_RELOAD, 8'h00);
    repeat (260) @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      #1;
      chk("phase", {7'h0, baud_tick[0]}, {7'h0, baud_tick[1]});
    end
    chk("phase_per", 8'h02, 8'(per[2]));
    // park port c slow on the prescaler output
    acc(1, ADDR_BAUD2_RELOAD, 8'hff);
    acc(1, ADDR_SOURCE_PRIORITY, 8'hc2);
    repeat (60) @(posedge clk);
    held = per[3];
    repeat (100) @(posedge clk);
    chk("parked", 8'(held), 8'(per[3]));
    // stop the base clock, keep enables, then collect flags
    acc(1, ADDR_CTRL_STATUS, 8'hf2);
    repeat (4) @(posedge clk);
    acc(0, ADDR_CTRL_STATUS, 8'hf2);
    repeat (2) @(posedge clk);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    acc(0, ADDR_CTRL_STATUS, 8'h00);
    acc(0, ADDR_BAUD2_RELOAD, 8'h00);
    acc(0, 8'h55, 8'h00);
    stop_test();
  end
endmodule
